// File: logic/cop_top.sv
// clock output prescaler: register slave, rate update scheme, pad controls
`timescale 1ns/1ps
`include "cop_cfg.svh"
module cop_top #(
  parameter int SETTLE_CYCLES = `COP_SETTLE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic por_b_in,
  input wire logic osc_edge_in,
  input wire logic sleep_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic ref_clock_out,
  output logic [1:0] clkout_drive_sel_out,
  output logic [1:0] pad_io_drive_out,
  output logic [3:0] osc_source_mode_out,
  output logic [3:0] osc_load_trim_out,
  output logic crystal_osc_en_out,
  output logic osc_settled_out
);
  // ***************************************************
  // declarations
  // ***************************************************
  logic aw_held, next_aw_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  cop_pkg::cop_wbuf_s wbuf, next_wbuf;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [7:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic wr_fire;
  logic wr_hit;
  logic wr_ctrl;
  logic wr_osc;
  logic rd_fire;
  logic [7:0] rd_mux;
  logic rd_hit;
  cop_pkg::cop_ctrl_s ctrl, next_ctrl;
  cop_pkg::cop_ctrl_s wr_ctrl_val;
  cop_pkg::cop_osc_s osc, next_osc;
  cop_pkg::cop_rate_t active_rate, next_active_rate;
  cop_pkg::cop_rate_t cur_rate;
  logic wake;
  logic settled;
  logic [7:0] addr_ctrl;
  logic [7:0] addr_osc;
  logic [7:0] addr_stat;

  // byte addresses are four times the register index
  assign addr_ctrl = {`COP_IDX_CTRL, 2'b00};
  assign addr_osc = {`COP_IDX_OSC, 2'b00};
  assign addr_stat = {`COP_IDX_STAT, 2'b00};

  // ***************************************************
  // axi4-lite write channel
  // ***************************************************
  // address and data are held apart so they may arrive in any order
  assign s_axi_awready_out = !aw_held;
  assign s_axi_wready_out = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;

  // write decode
  always_comb begin
    wr_hit = 1'b0;
    wr_ctrl = 1'b0;
    wr_osc = 1'b0;
    if (aw_addr == addr_ctrl) begin
      wr_hit = 1'b1;
      wr_ctrl = wr_fire && wbuf.strb;
    end else if (aw_addr == addr_osc) begin
      wr_hit = 1'b1;
      wr_osc = wr_fire && wbuf.strb;
    end
  end

  // next write channel state
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_wbuf = wbuf;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid_in && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_held) begin
      next_w_held = 1'b1;
      next_wbuf.data = s_axi_wdata_in[7:0];
      next_wbuf.strb = s_axi_wstrb_in[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? `COP_RESP_OKAY : `COP_RESP_SLVERR;
    end else if (bvalid && s_axi_bready_in) begin
      next_bvalid = 1'b0;
    end
  end

  // write channel registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      wbuf <= '0;
      bvalid <= 1'b0;
      bresp <= `COP_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      wbuf <= next_wbuf;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;

  // ***************************************************
  // axi4-lite read channel
  // ***************************************************
  // one read in flight; a new address waits until the answer is taken
  assign s_axi_arready_out = !rvalid;
  assign rd_fire = s_axi_arvalid_in && !rvalid;

  // read decode; the status word shows live wake state and running rate
  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr_in == addr_ctrl) begin
      rd_mux = ctrl;
    end else if (s_axi_araddr_in == addr_osc) begin
      rd_mux = osc;
    end else if (s_axi_araddr_in == addr_stat) begin
      rd_mux = {4'h0, cur_rate, settled};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // next read channel state
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rdata = rd_mux;
      next_rresp = rd_hit ? `COP_RESP_OKAY : `COP_RESP_SLVERR;
    end else if (rvalid && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
  end

  // read channel registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rvalid <= 1'b0;
      rdata <= 8'h00;
      rresp <= `COP_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = {24'h000000, rdata};
  assign s_axi_rresp_out = rresp;

  // ***************************************************
  // control registers
  // ***************************************************
  assign wr_ctrl_val = wbuf.data;

  // software fields; byte lane zero carries the whole register
  always_comb begin
    next_ctrl = ctrl;
    next_osc = osc;
    if (wr_ctrl) begin
      next_ctrl = wr_ctrl_val;
    end
    if (wr_osc) begin
      next_osc = wbuf.data;
    end
  end

  // ordinary reset returns the fields, rate reads back as one
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= `COP_CTRL_RST;
      osc <= `COP_OSC_RST;
    end else begin
      ctrl <= next_ctrl;
      osc <= next_osc;
    end
  end

  // ***************************************************
  // rate update scheme
  // ***************************************************
  // the rate that drives the pin lives in the power on domain, so a plain
  // reset leaves it alone; a sleep exit reloads it from the field, which
  // after a reset without rewrite means falling back to 1 MHz
  always_comb begin
    next_active_rate = active_rate;
    if (wake) begin
      next_active_rate = ctrl.rate;
    end
    if (wr_ctrl && (!ctrl.defer || ctrl.rate == `COP_RATE_OFF)) begin
      next_active_rate = wr_ctrl_val.rate;
    end
  end

  // active rate register, untouched by the ordinary reset
  always_ff @(posedge clk_sys_in or negedge por_b_in) begin
    if (!por_b_in) begin
      active_rate <= `COP_RATE_1M;
    end else begin
      active_rate <= next_active_rate;
    end
  end

  // ***************************************************
  // oscillator wake and prescaler
  // ***************************************************
  cop_settle_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .sleep_in(sleep_in),
    .wake_out(wake),
    .settled_out(settled)
  );

  // pin held low until the oscillator has settled
  cop_divider u_div (
    .clk_sys_in(clk_sys_in),
    .por_b_in(por_b_in),
    .osc_edge_in(osc_edge_in),
    .hold_low_in(!settled),
    .rate_in(active_rate),
    .clk_out(ref_clock_out),
    .cur_rate_out(cur_rate)
  );

  // ***************************************************
  // pad and oscillator controls
  // ***************************************************
  // all but osc_settled_out come from register bits, crystal_osc_en_out decoded from osc.mode, so they stand still between writes
  assign clkout_drive_sel_out = ctrl.drive;
  assign pad_io_drive_out = ctrl.pad_io;
  assign osc_source_mode_out = osc.mode;
  assign osc_load_trim_out = osc.trim;
  assign crystal_osc_en_out = (osc.mode == `COP_MODE_XTAL);
  assign osc_settled_out = settled;
endmodule

// File: logic/cop_cfg.svh
// constants of the clock output prescaler: offsets, reset values, codes, timing
`ifndef COP_CFG_SVH
`define COP_CFG_SVH

// ***************************************************
// register indices (byte address is four times these)
// ***************************************************
`define COP_IDX_CTRL 6'h03
`define COP_IDX_OSC 6'h12
`define COP_IDX_STAT 6'h20

// ***************************************************
// reset values and codes
// ***************************************************
`define COP_CTRL_RST 8'h09
`define COP_OSC_RST 8'hF0
`define COP_RATE_OFF 3'h0
`define COP_RATE_1M 3'h1
`define COP_RATE_2M 3'h2
`define COP_RATE_4M 3'h3
`define COP_RATE_8M 3'h4
`define COP_RATE_16M 3'h5
`define COP_RATE_250K 3'h6
`define COP_RATE_62K5 3'h7
`define COP_MODE_XTAL 4'hF
`define COP_MODE_EXT 4'h4
`define COP_RESP_OKAY 2'h0
`define COP_RESP_SLVERR 2'h2

// ***************************************************
// oscillator edges per output half period, minus one
// ***************************************************
`define COP_HALF_16M 8'h00
`define COP_HALF_8M 8'h01
`define COP_HALF_4M 8'h03
`define COP_HALF_2M 8'h07
`define COP_HALF_1M 8'h0F
`define COP_HALF_250K 8'h3F
`define COP_HALF_62K5 8'hFF

// ***************************************************
// timing
// ***************************************************
`define COP_CLK_MHZ 40
`define COP_SETTLE_NS 330000
`define COP_SETTLE_CYC ((`COP_SETTLE_NS * `COP_CLK_MHZ + 999) / 1000)

`endif

// File: logic/cop_pkg.sv
// types shared by the clock output prescaler files
package cop_pkg;
  typedef logic [2:0] cop_rate_t;

  // pad and clock output control register layout, msb first
  typedef struct packed {
    logic [1:0] pad_io;
    logic [1:0] drive;
    logic defer;
    cop_rate_t rate;
  } cop_ctrl_s;

  // oscillator control register layout
  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] trim;
  } cop_osc_s;

  // held write data beat
  typedef struct packed {
    logic [7:0] data;
    logic strb;
  } cop_wbuf_s;

  // oscillator wake states, gray along run, sleep, settle
  typedef enum logic [1:0] {
    COP_ST_RUN = 2'b00,
    COP_ST_SLEEP = 2'b01,
    COP_ST_SETTLE = 2'b11
  } cop_state_e;
endpackage

// File: logic/cop_settle_timer.sv
// sleep tracking and oscillator settle timer
`timescale 1ns/1ps
`include "cop_cfg.svh"
module cop_settle_timer #(
  parameter int SETTLE_CYCLES = `COP_SETTLE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic sleep_in,
  output logic wake_out,
  output logic settled_out
);
  cop_pkg::cop_state_e state, next_state;
  logic [15:0] cnt, next_cnt;

  // next state: sleep, then count the settle interval after leaving it
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      cop_pkg::COP_ST_RUN: begin
        if (sleep_in) begin
          next_state = cop_pkg::COP_ST_SLEEP;
        end
      end
      cop_pkg::COP_ST_SLEEP: begin
        next_cnt = 16'h0000;
        if (!sleep_in) begin
          next_state = cop_pkg::COP_ST_SETTLE;
        end
      end
      cop_pkg::COP_ST_SETTLE: begin
        if (sleep_in) begin
          next_state = cop_pkg::COP_ST_SLEEP;
        end else if (cnt == 16'(SETTLE_CYCLES - 1)) begin
          next_state = cop_pkg::COP_ST_RUN;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      default: begin
        next_state = cop_pkg::COP_ST_RUN;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= cop_pkg::COP_ST_RUN;
      cnt <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // wake is the single cycle in which sleep is left
  assign wake_out = (state == cop_pkg::COP_ST_SLEEP) && !sleep_in;
  assign settled_out = (state == cop_pkg::COP_ST_RUN);
endmodule

// File: logic/cop_divider.sv
// prescaler from oscillator edge ticks to the clock output pin, glitch free across rate switches
`timescale 1ns/1ps
`include "cop_cfg.svh"
module cop_divider (
  input wire logic clk_sys_in,
  input wire logic por_b_in,
  input wire logic osc_edge_in,
  input wire logic hold_low_in,
  input wire cop_pkg::cop_rate_t rate_in,
  output logic clk_out,
  output cop_pkg::cop_rate_t cur_rate_out
);
  cop_pkg::cop_rate_t cur_rate, next_cur_rate;
  logic [7:0] cnt, next_cnt;
  logic out_q, next_out_q;
  logic [7:0] half;

  // half period length for the rate now running
  always_comb begin
    case (cur_rate)
      `COP_RATE_1M: half = `COP_HALF_1M;
      `COP_RATE_2M: half = `COP_HALF_2M;
      `COP_RATE_4M: half = `COP_HALF_4M;
      `COP_RATE_8M: half = `COP_HALF_8M;
      `COP_RATE_16M: half = `COP_HALF_16M;
      `COP_RATE_250K: half = `COP_HALF_250K;
      `COP_RATE_62K5: half = `COP_HALF_62K5;
      default: half = `COP_HALF_1M;
    endcase
  end

  // a new rate is taken only while the pin is idle low or at the end of a
  // full period, so a rate switch never sends a short pulse to the host
  always_comb begin
    next_cur_rate = cur_rate;
    next_cnt = cnt;
    next_out_q = out_q;
    if (hold_low_in) begin
      next_out_q = 1'b0;
      next_cnt = 8'h00;
    end else if (osc_edge_in) begin
      if (cur_rate == `COP_RATE_OFF) begin
        next_out_q = 1'b0;
        next_cnt = 8'h00;
        next_cur_rate = rate_in;
      end else if (cnt == half) begin
        next_cnt = 8'h00;
        next_out_q = !out_q;
        if (out_q) begin
          next_cur_rate = rate_in;
        end
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  // only power on clears the divider, so a plain reset keeps the clock
  always_ff @(posedge clk_sys_in or negedge por_b_in) begin
    if (!por_b_in) begin
      cur_rate <= `COP_RATE_1M;
      cnt <= 8'h00;
      out_q <= 1'b0;
    end else begin
      cur_rate <= next_cur_rate;
      cnt <= next_cnt;
      out_q <= next_out_q;
    end
  end

  assign clk_out = out_q;
  assign cur_rate_out = cur_rate;
endmodule

// File: tb/cop_top_chk.sv
// port level assertion checker for the clock output prescaler
`timescale 1ns/1ps
module cop_top_chk #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic sleep_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_bvalid_out,
  input wire logic ref_clock_out,
  input wire logic [1:0] clkout_drive_sel_out,
  input wire logic [1:0] pad_io_drive_out,
  input wire logic [3:0] osc_source_mode_out,
  input wire logic [3:0] osc_load_trim_out,
  input wire logic crystal_osc_en_out,
  input wire logic osc_settled_out
);
  // ***************************
  // wake counter and assertions
  // ***************************
  logic [15:0] wake_cnt;
  logic [15:0] next_wake_cnt;
  logic rd_take;
  assign rd_take = s_axi_arvalid_in && s_axi_arready_out;
  // saturates so a long awake run never wraps into the settle window
  always_comb begin
    next_wake_cnt = (wake_cnt == 16'hFFFF) ? wake_cnt : wake_cnt + 16'h0001;
    if (sleep_in) next_wake_cnt = 16'h0000;
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) wake_cnt <= 16'h0000;
    else wake_cnt <= next_wake_cnt;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  a_ctrl_read_pads: assert property (
    rd_take && s_axi_araddr_in == 8'h0C |=>
    s_axi_rdata_out[7:4] == {pad_io_drive_out, clkout_drive_sel_out}) else $error("ctrl readback");
  a_osc_read_back: assert property (
    rd_take && s_axi_araddr_in == 8'h48 |=>
    s_axi_rdata_out[7:0] == {osc_source_mode_out, osc_load_trim_out}) else $error("osc readback");
  a_crystal_en_mode: assert property (
    crystal_osc_en_out == (osc_source_mode_out == 4'hF)) else $error("crystal enable");
  a_drive_on_write: assert property (
    $changed(clkout_drive_sel_out) |-> $rose(s_axi_bvalid_out)) else $error("drive changed alone");
  a_trim_on_write: assert property (
    $changed(osc_load_trim_out) |-> $rose(s_axi_bvalid_out)) else $error("trim changed alone");
  a_sleep_unsettled: assert property (
    sleep_in ##1 sleep_in |-> !osc_settled_out) else $error("settled while asleep");
  a_settle_time: assert property (
    $rose(osc_settled_out) |->
    wake_cnt inside {[SETTLE_CYCLES - 2 : SETTLE_CYCLES + 2]}) else $error("settle time");
  a_pin_low_settle: assert property (
    !osc_settled_out [*3] |-> !ref_clock_out) else $error("pin runs unsettled");
  a_status_settled: assert property (
    rd_take && s_axi_araddr_in == 8'h80 |=>
    s_axi_rdata_out[0] == $past(osc_settled_out)) else $error("status settled");
  // entering sleep pulls the pin low at once, which is not a rate switch
  a_no_runt_high: assert property (
    $rose(ref_clock_out) && osc_settled_out |=> ref_clock_out || !osc_settled_out)
    else $error("short high pulse");
  a_no_runt_low: assert property (
    $fell(ref_clock_out) |=> !ref_clock_out) else $error("short low pulse");
  c_wake: cover property ($fell(sleep_in));
  c_settled: cover property ($rose(osc_settled_out));
  c_write: cover property ($rose(s_axi_bvalid_out));
endmodule
bind cop_top cop_top_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sleep_in(sleep_in),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .ref_clock_out(ref_clock_out),
  .clkout_drive_sel_out(clkout_drive_sel_out), .pad_io_drive_out(pad_io_drive_out),
  .osc_source_mode_out(osc_source_mode_out), .osc_load_trim_out(osc_load_trim_out),
  .crystal_osc_en_out(crystal_osc_en_out), .osc_settled_out(osc_settled_out));

// File: tb/cop_host_model.sv
// oscillator edge source and host that times the output clock halves
`timescale 1ns/1ps
module cop_host_model (
  input wire logic clk_sys_in,
  input wire logic ref_clock_in,
  output logic osc_edge_out,
  output logic [15:0] half_len_out,
  output logic [7:0] edge_cnt_out
);
  // ************************
  // edge source and timing
  // ************************
  logic [15:0] run;
  logic last;
  initial begin
    osc_edge_out = 1'b0;
    run = 16'h0000;
    last = 1'b0;
    half_len_out = 16'h0000;
    edge_cnt_out = 8'h00;
  end
  // an edge every other cycle, so one half period is two cycles per edge
  always @(posedge clk_sys_in) begin
    osc_edge_out <= !osc_edge_out;
    last <= ref_clock_in;
    if (ref_clock_in !== last) begin
      half_len_out <= run + 16'h0001;
      run <= 16'h0000;
      edge_cnt_out <= edge_cnt_out + 8'h01;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule

// File: tb/clock_output_prescaler_test.sv
// self checking bench for the clock output prescaler
`timescale 1ns/1ps
`include "cop_cfg.svh"
module clock_output_prescaler_test;
  // ************************
  // signals and instances
  // ************************
  logic clk_sys_in, rst_b_in, por_b_in, osc_edge_in, sleep_in, ref_clk, xen, settled;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, ecnt;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, mode, trim, t;
  logic [1:0] bresp, rresp, drv, pio;
  logic [15:0] half_len;
  logic [33:0] mon_e;
  logic [33:0] q[$];
  logic [7:0] hv[8] = '{8'h00, `COP_HALF_1M, `COP_HALF_2M, `COP_HALF_4M, `COP_HALF_8M,
    `COP_HALF_16M, `COP_HALF_250K, `COP_HALF_62K5};
  int fails, checked, cyc;
  cop_top #(.SETTLE_CYCLES(8)) uut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .por_b_in(por_b_in), .osc_edge_in(osc_edge_in), .sleep_in(sleep_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .ref_clock_out(ref_clk), .clkout_drive_sel_out(drv),
    .pad_io_drive_out(pio), .osc_source_mode_out(mode), .osc_load_trim_out(trim),
    .crystal_osc_en_out(xen), .osc_settled_out(settled));
  cop_host_model host (.clk_sys_in(clk_sys_in), .ref_clock_in(ref_clk),
    .osc_edge_out(osc_edge_in), .half_len_out(half_len), .edge_cnt_out(ecnt));
  // ************************
  // tasks
  // ************************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t %s: saw %0h want %0h", $time, what, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // expected half period in bus cycles, two cycles per oscillator edge
  function automatic logic [15:0] hc(input logic [2:0] r);
    hc = ({8'h00, hv[r]} + 16'h0001) << 1;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
    input logic [1:0] rsp);
    q.push_back({rsp, 32'h0});
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // three pin changes guarantee the last measured half is at the new rate
  task automatic measure(input logic [15:0] exp);
    logic [7:0] c0;
    c0 = ecnt;
    while (8'(ecnt - c0) < 8'h03) @(posedge clk_sys_in);
    check({18'h0, half_len}, {18'h0, exp}, "half period");
  endtask
  task automatic nap;
    sleep_in <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    sleep_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    check({33'h0, settled}, 34'h0, "settling");
    repeat (12) @(posedge clk_sys_in);
    check({33'h0, settled}, 34'h1, "settled");
  endtask
  task automatic pulse_rst;
    @(posedge clk_sys_in);
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
  endtask
  // ************************
  // clock, monitor, timeout
  // ************************
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // responses are matched in issue order, one transfer is open at a time
  always @(posedge clk_sys_in) begin
    if (rvalid === 1'b1 && rready) begin
      mon_e = q.pop_front();
      check({rresp, rdata}, mon_e, "read");
    end else if (bvalid === 1'b1 && bready) begin
      mon_e = q.pop_front();
      check({bresp, 32'h0}, {mon_e[33:32], 32'h0}, "write response");
    end
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ************************
  // main sequence
  // ************************
  initial begin
    {rst_b_in, por_b_in, sleep_in, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    void'($urandom(32'hEDF3498B));
    repeat (20) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    por_b_in <= 1'b1;
    rd(8'h0C, {2'h0, 32'h09});
    rd(8'h48, {2'h0, 24'h0, `COP_MODE_XTAL, 4'h0});
    rd(8'h80, {2'h0, 28'h0, `COP_RATE_1M, 1'b1});
    rd(8'h04, {`COP_RESP_SLVERR, 32'h0});
    measure(hc(`COP_RATE_1M));
    for (int r = 1; r < 8; r++) begin
      d = {24'h0, 2'($urandom), 2'($urandom), 1'b0, 3'(r)};
      wr(8'h0C, d, 4'hF, 2'h0);
      measure(hc(3'(r)));
      check({32'h0, drv}, {32'h0, d[5:4]}, "drive select");
      rd(8'h80, {2'h0, 28'h0, 3'(r), 1'b1});
    end
    wr(8'h0C, 32'h00, 4'hF, 2'h0);
    // the slowest rate finishes its full period before the pin parks low
    repeat (1100) @(posedge clk_sys_in);
    d[7:0] = ecnt;
    repeat (300) @(posedge clk_sys_in);
    check({26'h0, ecnt}, {26'h0, d[7:0]}, "pin idle when off");
    check({33'h0, ref_clk}, 34'h0, "pin low when off");
    wr(8'h0C, 32'h0D, 4'hF, 2'h0);
    measure(hc(`COP_RATE_16M));
    wr(8'h0C, 32'h0A, 4'hF, 2'h0);
    measure(hc(`COP_RATE_16M));
    rd(8'h0C, {2'h0, 32'h0A});
    nap();
    measure(hc(`COP_RATE_2M));
    wr(8'h0C, 32'h04, 4'hF, 2'h0);
    pulse_rst();
    rd(8'h0C, {2'h0, 32'h09});
    measure(hc(`COP_RATE_2M));
    nap();
    measure(hc(`COP_RATE_1M));
    wr(8'h0C, 32'h03, 4'hF, 2'h0);
    pulse_rst();
    wr(8'h0C, 32'h0B, 4'hF, 2'h0);
    nap();
    measure(hc(`COP_RATE_4M));
    wr(8'h0C, $urandom, 4'h0, 2'h0);
    rd(8'h0C, {2'h0, 32'h0B});
    wr(8'h80, 32'h0, 4'hF, `COP_RESP_SLVERR);
    t = 4'($urandom);
    wr(8'h48, {24'h0, `COP_MODE_EXT, t}, 4'hF, 2'h0);
    check({25'h0, mode, trim, xen}, {25'h0, `COP_MODE_EXT, t, 1'b0}, "osc outputs");
    rd(8'h48, {2'h0, 24'h0, `COP_MODE_EXT, t});
    wr(8'h48, {24'h0, `COP_MODE_XTAL, t}, 4'hF, 2'h0);
    check({33'h0, xen}, 34'h1, "crystal enabled");
    tally_and_finish();
  end
endmodule
